// file: logic/oss_pkg.sv
// Constants for the output status selector
//----------------------------------------------------------------------
// Behaviour
//----------------------------------------------------------------------
// Behaviour
// - Run code drives terminal on in run mode, off in stop mode.
// - Constant-speed arrival: on only at set frequency, off when stopped or ramping.
// - Over-frequency arrival: on at or above level, even ramping; off otherwise.
// - Overload warning: on while current exceeds threshold, off below it.
// - PID deviation: on while PID error exceeds threshold, off below it.
// - Alarm: on once an alarm occurs, held until cleared.
// - Set-frequency arrival: on when output equals level, ramps included.
// - Torque level: on while estimated torque exceeds level, off below.
// - Undervoltage: on while the drive is undervoltage, off otherwise.
// - Torque limiting: on while the torque limit is acting.
// - Run-time expiry: on once accumulated run time exceeds limit.
// - Power-on expiry: on once accumulated powered time exceeds limit.
// - Thermal warning: on while thermal count exceeds setting.
// - Brake release: on to command brake release, off otherwise.
// - Brake error: on when brake fault detected, off when normal.
// - Two general outputs and the alarm relay each have own option code.
package oss_pkg;
    //------------------------------------------------------------------
    // Sizes
    //------------------------------------------------------------------
    localparam int OSS_NTERM = 3;
    localparam int OSS_AW = 8;
    localparam int OSS_DW = 16;

    //------------------------------------------------------------------
    // Option codes
    //------------------------------------------------------------------
    localparam logic [7:0] OSS_CODE_RUN = 8'h00;
    localparam logic [7:0] OSS_CODE_FA_CONST = 8'h01;
    localparam logic [7:0] OSS_CODE_FA_OVER = 8'h02;
    localparam logic [7:0] OSS_CODE_OVERLOAD = 8'h03;
    localparam logic [7:0] OSS_CODE_PID_DEV = 8'h04;
    localparam logic [7:0] OSS_CODE_ALARM = 8'h05;
    localparam logic [7:0] OSS_CODE_FA_SET = 8'h06;
    localparam logic [7:0] OSS_CODE_TORQUE = 8'h07;
    localparam logic [7:0] OSS_CODE_UNDERVOLT = 8'h09;
    localparam logic [7:0] OSS_CODE_TRQ_LIMIT = 8'h0A;
    localparam logic [7:0] OSS_CODE_RUN_TIME = 8'h0B;
    localparam logic [7:0] OSS_CODE_ON_TIME = 8'h0C;
    localparam logic [7:0] OSS_CODE_THERMAL = 8'h0D;
    localparam logic [7:0] OSS_CODE_BRAKE_REL = 8'h13;
    localparam logic [7:0] OSS_CODE_BRAKE_ERR = 8'h14;

    //------------------------------------------------------------------
    // Register offsets
    //------------------------------------------------------------------
    localparam logic [7:0] OSS_REG_SEL0 = 8'h00;
    localparam logic [7:0] OSS_REG_SEL1 = 8'h04;
    localparam logic [7:0] OSS_REG_SEL2 = 8'h08;
    localparam logic [7:0] OSS_REG_FREQ_LVL = 8'h0C;
    localparam logic [7:0] OSS_REG_OL_THR = 8'h10;
    localparam logic [7:0] OSS_REG_PID_THR = 8'h14;
    localparam logic [7:0] OSS_REG_TRQ_THR = 8'h18;
    localparam logic [7:0] OSS_REG_RUN_LIM = 8'h1C;
    localparam logic [7:0] OSS_REG_ON_LIM = 8'h20;
    localparam logic [7:0] OSS_REG_THM_LIM = 8'h24;
    localparam logic [7:0] OSS_REG_STATE = 8'h28;
    localparam logic [7:0] OSS_REG_IRQ_STAT = 8'h2C;
    localparam logic [7:0] OSS_REG_IRQ_MASK = 8'h30;
    localparam logic [7:0] OSS_REG_RUN_CNT = 8'h34;
    localparam logic [7:0] OSS_REG_ON_CNT = 8'h38;

    //------------------------------------------------------------------
    // Reset values and fields
    //------------------------------------------------------------------
    localparam logic [7:0] OSS_SEL_RST = 8'hFF;
    localparam logic [15:0] OSS_THR_RST = 16'hFFFF;
    localparam logic [3:0] OSS_IRQ_RST = 4'h0;
    localparam int OSS_IRQ_ALARM_BIT = 3;
    localparam int OSS_STATE_FAULT_BIT = 3;
endpackage : oss_pkg

// file: logic/oss_output_selector.sv
// Output status selector: per-terminal condition mux with register port
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/10ps
module oss_output_selector
    import oss_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    // Register port
    input wire logic [OSS_AW-1:0] reg_addr,
    input wire logic [OSS_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [OSS_DW-1:0] reg_rdata,
    output logic irq,
    // Drive status
    input wire logic run_mode,
    input wire logic motor_on,
    input wire logic ramping,
    input wire logic [15:0] out_freq,
    input wire logic [15:0] set_freq,
    input wire logic [15:0] out_current,
    input wire logic [15:0] pid_error,
    input wire logic [15:0] torque_est,
    input wire logic [15:0] thermal_count,
    input wire logic alarm_event,
    input wire logic alarm_clear,
    input wire logic low_supply_flag,
    input wire logic torque_clamp_flag,
    input wire logic brake_release_req,
    input wire logic brake_fault_flag,
    input wire logic hour_tick,
    // Terminals: 0 and 1 general, 2 alarm relay
    output logic [OSS_NTERM-1:0] term_out
);

    //------------------------------------------------------------------
    // Configuration registers
    //------------------------------------------------------------------
    logic [7:0] sel_r [OSS_NTERM];
    logic [15:0] freq_lvl_r;
    logic [15:0] ol_thr_r;
    logic [15:0] pid_thr_r;
    logic [15:0] trq_thr_r;
    logic [15:0] run_lim_r;
    logic [15:0] on_lim_r;
    logic [15:0] thm_lim_r;
    logic [3:0] irq_stat_r;
    logic [3:0] irq_mask_r;
    logic [15:0] rdata_r;
    logic irq_r;
    logic fault_flag_r;
    logic [15:0] run_hours_r;
    logic [15:0] on_hours_r;
    logic [OSS_NTERM-1:0] term_r;
    logic [OSS_NTERM-1:0] term_nxt;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < OSS_NTERM; i++) begin
                sel_r[i] <= OSS_SEL_RST;
            end
            freq_lvl_r <= OSS_THR_RST;
            ol_thr_r <= OSS_THR_RST;
            pid_thr_r <= OSS_THR_RST;
            trq_thr_r <= OSS_THR_RST;
            run_lim_r <= OSS_THR_RST;
            on_lim_r <= OSS_THR_RST;
            thm_lim_r <= OSS_THR_RST;
            irq_mask_r <= OSS_IRQ_RST;
        end else if (ce && reg_wr) begin
            case (reg_addr)
                OSS_REG_SEL0: sel_r[0] <= reg_wdata[7:0];
                OSS_REG_SEL1: sel_r[1] <= reg_wdata[7:0];
                OSS_REG_SEL2: sel_r[2] <= reg_wdata[7:0];
                OSS_REG_FREQ_LVL: freq_lvl_r <= reg_wdata;
                OSS_REG_OL_THR: ol_thr_r <= reg_wdata;
                OSS_REG_PID_THR: pid_thr_r <= reg_wdata;
                OSS_REG_TRQ_THR: trq_thr_r <= reg_wdata;
                OSS_REG_RUN_LIM: run_lim_r <= reg_wdata;
                OSS_REG_ON_LIM: on_lim_r <= reg_wdata;
                OSS_REG_THM_LIM: thm_lim_r <= reg_wdata;
                OSS_REG_IRQ_MASK: irq_mask_r <= reg_wdata[3:0];
                default: ;
            endcase
        end
    end

    //------------------------------------------------------------------
    // Condition flags
    //------------------------------------------------------------------
    logic speed_reached_flag;
    logic above_setpoint_flag;
    logic at_setpoint_flag;
    logic overcurrent_warn_flag;
    logic pid_error_flag;
    logic torque_window_flag;
    logic run_hours_flag;
    logic uptime_flag;
    logic heat_count_flag;

    assign speed_reached_flag = motor_on && !ramping && (out_freq == set_freq);
    assign above_setpoint_flag = motor_on && (out_freq >= freq_lvl_r);
    assign at_setpoint_flag = motor_on && (out_freq == freq_lvl_r);
    assign overcurrent_warn_flag = out_current > ol_thr_r;
    assign pid_error_flag = pid_error > pid_thr_r;
    assign torque_window_flag = torque_est > trq_thr_r;
    assign run_hours_flag = run_hours_r > run_lim_r;
    assign uptime_flag = on_hours_r > on_lim_r;
    assign heat_count_flag = thermal_count > thm_lim_r;

    // Sticky alarm, a new alarm beats a clear
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fault_flag_r <= 1'b0;
        end else if (ce) begin
            if (alarm_event) begin
                fault_flag_r <= 1'b1;
            end else if (alarm_clear) begin
                fault_flag_r <= 1'b0;
            end
        end
    end

    // Saturating hour accumulators
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            run_hours_r <= 16'h0000;
            on_hours_r <= 16'h0000;
        end else if (ce && hour_tick) begin
            if (run_mode && run_hours_r != 16'hFFFF) begin
                run_hours_r <= run_hours_r + 16'h0001;
            end
            if (on_hours_r != 16'hFFFF) begin
                on_hours_r <= on_hours_r + 16'h0001;
            end
        end
    end

    //------------------------------------------------------------------
    // Per-terminal selection
    //------------------------------------------------------------------
    generate
        for (genvar t = 0; t < OSS_NTERM; t++) begin : g_term
            always_comb begin
                case (sel_r[t])
                    OSS_CODE_RUN: term_nxt[t] = run_mode;
                    OSS_CODE_FA_CONST: term_nxt[t] = speed_reached_flag;
                    OSS_CODE_FA_OVER: term_nxt[t] = above_setpoint_flag;
                    OSS_CODE_OVERLOAD: term_nxt[t] = overcurrent_warn_flag;
                    OSS_CODE_PID_DEV: term_nxt[t] = pid_error_flag;
                    OSS_CODE_ALARM: term_nxt[t] = fault_flag_r;
                    OSS_CODE_FA_SET: term_nxt[t] = at_setpoint_flag;
                    OSS_CODE_TORQUE: term_nxt[t] = torque_window_flag;
                    OSS_CODE_UNDERVOLT: term_nxt[t] = low_supply_flag;
                    OSS_CODE_TRQ_LIMIT: term_nxt[t] = torque_clamp_flag;
                    OSS_CODE_RUN_TIME: term_nxt[t] = run_hours_flag;
                    OSS_CODE_ON_TIME: term_nxt[t] = uptime_flag;
                    OSS_CODE_THERMAL: term_nxt[t] = heat_count_flag;
                    OSS_CODE_BRAKE_REL: term_nxt[t] = brake_release_req;
                    OSS_CODE_BRAKE_ERR: term_nxt[t] = brake_fault_flag;
                    default: term_nxt[t] = 1'b0;
                endcase
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            term_r <= '0;
        end else if (ce) begin
            term_r <= term_nxt;
        end
    end

    //------------------------------------------------------------------
    // Interrupts
    //------------------------------------------------------------------
    logic [3:0] irq_set;
    logic [3:0] irq_clr;
    logic [3:0] irq_mask_nxt;

    assign irq_set = {alarm_event, term_nxt & ~term_r};
    assign irq_clr = (reg_wr && reg_addr == OSS_REG_IRQ_STAT) ? reg_wdata[3:0] : 4'h0;
    // Mask written this cycle already gates the new level
    assign irq_mask_nxt = (reg_wr && reg_addr == OSS_REG_IRQ_MASK) ?
        reg_wdata[3:0] : irq_mask_r;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_stat_r <= OSS_IRQ_RST;
        end else if (ce) begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_r <= 1'b0;
        end else if (ce) begin
            irq_r <= |(((irq_stat_r & ~irq_clr) | irq_set) & irq_mask_nxt);
        end
    end

    //------------------------------------------------------------------
    // Read port
    //------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_r <= 16'h0000;
        end else if (ce) begin
            rdata_r <= 16'h0000;
            if (reg_rd) begin
                case (reg_addr)
                    OSS_REG_SEL0: rdata_r <= {8'h00, sel_r[0]};
                    OSS_REG_SEL1: rdata_r <= {8'h00, sel_r[1]};
                    OSS_REG_SEL2: rdata_r <= {8'h00, sel_r[2]};
                    OSS_REG_FREQ_LVL: rdata_r <= freq_lvl_r;
                    OSS_REG_OL_THR: rdata_r <= ol_thr_r;
                    OSS_REG_PID_THR: rdata_r <= pid_thr_r;
                    OSS_REG_TRQ_THR: rdata_r <= trq_thr_r;
                    OSS_REG_RUN_LIM: rdata_r <= run_lim_r;
                    OSS_REG_ON_LIM: rdata_r <= on_lim_r;
                    OSS_REG_THM_LIM: rdata_r <= thm_lim_r;
                    OSS_REG_STATE: rdata_r <= {12'h000, fault_flag_r, term_r};
                    OSS_REG_IRQ_STAT: rdata_r <= {12'h000, irq_stat_r};
                    OSS_REG_IRQ_MASK: rdata_r <= {12'h000, irq_mask_r};
                    OSS_REG_RUN_CNT: rdata_r <= run_hours_r;
                    OSS_REG_ON_CNT: rdata_r <= on_hours_r;
                    default: rdata_r <= 16'h0000;
                endcase
            end
        end
    end

    assign reg_rdata = rdata_r;
    assign irq = irq_r;
    assign term_out = term_r;

    //------------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------------
    property p_run_sel;
        @(posedge clk_sys) disable iff (rst)
        (ce && sel_r[0] == OSS_CODE_RUN) |=> (term_out[0] == $past(run_mode));
    endproperty
    a_run_sel: assert property (p_run_sel) else $error("run code mismatch");

    property p_fa_const;
        @(posedge clk_sys) disable iff (rst)
        (ce && sel_r[0] == OSS_CODE_FA_CONST && (ramping || !motor_on)) |=> !term_out[0];
    endproperty
    a_fa_const: assert property (p_fa_const) else $error("arrival on while ramping");

    property p_fa_over;
        @(posedge clk_sys) disable iff (rst)
        (ce && sel_r[1] == OSS_CODE_FA_OVER && motor_on && out_freq >= freq_lvl_r)
            |=> term_out[1];
    endproperty
    a_fa_over: assert property (p_fa_over) else $error("over frequency missed");

    property p_overload;
        @(posedge clk_sys) disable iff (rst)
        (ce && sel_r[0] == OSS_CODE_OVERLOAD) |=>
            (term_out[0] == ($past(out_current) > $past(ol_thr_r)));
    endproperty
    a_overload: assert property (p_overload) else $error("overload mismatch");

    sequence s_alarm_raised;
        ce && alarm_event;
    endsequence

    sequence s_alarm_held;
        (ce && !alarm_clear)[*2];
    endsequence

    property p_alarm_hold;
        @(posedge clk_sys) disable iff (rst)
        s_alarm_raised ##1 s_alarm_held |-> fault_flag_r;
    endproperty
    a_alarm_hold: assert property (p_alarm_hold) else $error("alarm not held");

    property p_alarm_clear;
        @(posedge clk_sys) disable iff (rst)
        (ce && alarm_clear && !alarm_event) |=> !fault_flag_r;
    endproperty
    a_alarm_clear: assert property (p_alarm_clear) else $error("alarm not cleared");

    property p_undervolt;
        @(posedge clk_sys) disable iff (rst)
        (ce && sel_r[2] == OSS_CODE_UNDERVOLT) |=> (term_out[2] == $past(low_supply_flag));
    endproperty
    a_undervolt: assert property (p_undervolt) else $error("undervoltage mismatch");

    property p_unknown_off;
        @(posedge clk_sys) disable iff (rst)
        (ce && sel_r[1] == OSS_SEL_RST) |=> !term_out[1];
    endproperty
    a_unknown_off: assert property (p_unknown_off) else $error("unknown code drove on");

    property p_brake_err;
        @(posedge clk_sys) disable iff (rst)
        (ce && sel_r[2] == OSS_CODE_BRAKE_ERR && brake_fault_flag) |=> term_out[2];
    endproperty
    a_brake_err: assert property (p_brake_err) else $error("brake error missed");

    property p_pid_dev;
        @(posedge clk_sys) disable iff (rst)
        (ce && sel_r[1] == OSS_CODE_PID_DEV) |=>
            (term_out[1] == ($past(pid_error) > $past(pid_thr_r)));
    endproperty
    a_pid_dev: assert property (p_pid_dev) else $error("pid deviation mismatch");

    property p_fa_set;
        @(posedge clk_sys) disable iff (rst)
        (ce && sel_r[2] == OSS_CODE_FA_SET) |=>
            (term_out[2] == ($past(motor_on) && ($past(out_freq) == $past(freq_lvl_r))));
    endproperty
    a_fa_set: assert property (p_fa_set) else $error("arrival level mismatch");

    property p_torque;
        @(posedge clk_sys) disable iff (rst)
        (ce && sel_r[0] == OSS_CODE_TORQUE) |=>
            (term_out[0] == ($past(torque_est) > $past(trq_thr_r)));
    endproperty
    a_torque: assert property (p_torque) else $error("torque level mismatch");

    property p_trq_limit;
        @(posedge clk_sys) disable iff (rst)
        (ce && sel_r[1] == OSS_CODE_TRQ_LIMIT) |=>
            (term_out[1] == $past(torque_clamp_flag));
    endproperty
    a_trq_limit: assert property (p_trq_limit) else $error("torque limit mismatch");

    property p_run_time;
        @(posedge clk_sys) disable iff (rst)
        (ce && sel_r[2] == OSS_CODE_RUN_TIME) |=>
            (term_out[2] == ($past(run_hours_r) > $past(run_lim_r)));
    endproperty
    a_run_time: assert property (p_run_time) else $error("run time mismatch");

    property p_on_time;
        @(posedge clk_sys) disable iff (rst)
        (ce && sel_r[0] == OSS_CODE_ON_TIME) |=>
            (term_out[0] == ($past(on_hours_r) > $past(on_lim_r)));
    endproperty
    a_on_time: assert property (p_on_time) else $error("power on time mismatch");

    property p_thermal;
        @(posedge clk_sys) disable iff (rst)
        (ce && sel_r[1] == OSS_CODE_THERMAL) |=>
            (term_out[1] == ($past(thermal_count) > $past(thm_lim_r)));
    endproperty
    a_thermal: assert property (p_thermal) else $error("thermal warning mismatch");

    property p_brake_rel;
        @(posedge clk_sys) disable iff (rst)
        (ce && sel_r[2] == OSS_CODE_BRAKE_REL) |=>
            (term_out[2] == $past(brake_release_req));
    endproperty
    a_brake_rel: assert property (p_brake_rel) else $error("brake release mismatch");

endmodule : oss_output_selector

// file: tb/oss_relay_model.sv
// Relay bank model wired to the terminal outputs
`timescale 1ns/10ps
module oss_relay_model
    import oss_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [OSS_NTERM-1:0] term_in,
    output logic [OSS_NTERM-1:0] contact_q
);
    //------------------------------------------------------------------
    // Contacts
    //------------------------------------------------------------------
    // Contacts follow the coils one clock late
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            contact_q <= '0;
        end else begin
            contact_q <= term_in;
        end
    end
endmodule : oss_relay_model

// file: tb/tb_output_status_selector.sv
// Self-checking bench for the output status selector
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module tb_output_status_selector
    import oss_pkg::*;
;
    //------------------------------------------------------------------
    // Signals
    //------------------------------------------------------------------
    logic clk_sys;
    logic rst = 1'b1, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic irq;
    logic [2:0] term_out, contact_q;
    logic run_mode = 0, motor_on = 0, ramping = 0, alarm_event = 0, alarm_clear = 0;
    logic low_supply_flag = 0, torque_clamp_flag = 0, brake_release_req = 0;
    logic brake_fault_flag = 0, hour_tick = 0;
    logic [15:0] out_freq = 0, set_freq = 0, out_current = 0, pid_error = 0;
    logic [15:0] torque_est = 0, thermal_count = 0;
    int seed = 32'h9A0F, error_cnt = 0, checked = 0;
    logic [7:0] codes [16] = '{OSS_CODE_RUN, OSS_CODE_FA_CONST, OSS_CODE_FA_OVER,
        OSS_CODE_OVERLOAD, OSS_CODE_PID_DEV, OSS_CODE_ALARM, OSS_CODE_FA_SET, OSS_CODE_TORQUE,
        8'h08, OSS_CODE_UNDERVOLT, OSS_CODE_TRQ_LIMIT, OSS_CODE_RUN_TIME, OSS_CODE_ON_TIME,
        OSS_CODE_THERMAL, OSS_CODE_BRAKE_REL, OSS_CODE_BRAKE_ERR};

    oss_output_selector oss_output_selector_i (.clk_sys(clk_sys), .rst(rst), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq), .run_mode(run_mode), .motor_on(motor_on),
        .ramping(ramping), .out_freq(out_freq), .set_freq(set_freq),
        .out_current(out_current), .pid_error(pid_error), .torque_est(torque_est),
        .thermal_count(thermal_count), .alarm_event(alarm_event), .alarm_clear(alarm_clear),
        .low_supply_flag(low_supply_flag), .torque_clamp_flag(torque_clamp_flag),
        .brake_release_req(brake_release_req), .brake_fault_flag(brake_fault_flag),
        .hour_tick(hour_tick), .term_out(term_out));
    oss_relay_model oss_relay_model_i (.clk_sys(clk_sys), .rst(rst), .term_in(term_out),
        .contact_q(contact_q));

    //------------------------------------------------------------------
    // Reference model
    //------------------------------------------------------------------
    logic [15:0] m_reg [16];
    logic [15:0] m_run_cnt, m_on_cnt, m_rd;
    logic [3:0] m_stat, m_mask, st, mk;
    logic [2:0] m_term, m_term_d, tn;
    logic m_alarm, m_irq, run_chk = 1'b0;

    function automatic logic cond(input logic [7:0] code);
        case (code)
            OSS_CODE_RUN: return run_mode;
            OSS_CODE_FA_CONST: return motor_on & ~ramping & (out_freq == set_freq);
            OSS_CODE_FA_OVER: return motor_on & (out_freq >= m_reg[3]);
            OSS_CODE_OVERLOAD: return out_current > m_reg[4];
            OSS_CODE_PID_DEV: return pid_error > m_reg[5];
            OSS_CODE_ALARM: return m_alarm;
            OSS_CODE_FA_SET: return motor_on & (out_freq == m_reg[3]);
            OSS_CODE_TORQUE: return torque_est > m_reg[6];
            OSS_CODE_UNDERVOLT: return low_supply_flag;
            OSS_CODE_TRQ_LIMIT: return torque_clamp_flag;
            OSS_CODE_RUN_TIME: return m_run_cnt > m_reg[7];
            OSS_CODE_ON_TIME: return m_on_cnt > m_reg[8];
            OSS_CODE_THERMAL: return thermal_count > m_reg[9];
            OSS_CODE_BRAKE_REL: return brake_release_req;
            OSS_CODE_BRAKE_ERR: return brake_fault_flag;
            default: return 1'b0;
        endcase
    endfunction : cond

    function automatic logic [15:0] rd_val(input logic [7:0] a);
        case (a)
            OSS_REG_STATE: return {12'h000, m_alarm, m_term};
            OSS_REG_IRQ_STAT: return {12'h000, m_stat};
            OSS_REG_IRQ_MASK: return {12'h000, m_mask};
            OSS_REG_RUN_CNT: return m_run_cnt;
            OSS_REG_ON_CNT: return m_on_cnt;
            default: return (a < OSS_REG_STATE && a[1:0] == 2'b00) ? m_reg[a[5:2]] : 16'h0000;
        endcase
    endfunction : rd_val

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 16; i++) m_reg[i] <= (i < 3) ? {8'h00, OSS_SEL_RST} : OSS_THR_RST;
            {m_run_cnt, m_on_cnt, m_rd} <= '0;
            {m_stat, m_mask, m_term, m_alarm, m_irq} <= '0;
        end else if (ce) begin
            for (int t = 0; t < 3; t++) tn[t] = cond(m_reg[t][7:0]);
            st = m_stat;
            if (reg_wr && reg_addr == OSS_REG_IRQ_STAT) st = st & ~reg_wdata[3:0];
            st = st | {alarm_event, tn & ~m_term};
            mk = (reg_wr && reg_addr == OSS_REG_IRQ_MASK) ? reg_wdata[3:0] : m_mask;
            m_stat <= st;
            m_mask <= mk;
            m_irq <= |(st & mk);
            m_term <= tn;
            m_alarm <= alarm_event | (m_alarm & ~alarm_clear);
            if (hour_tick && m_on_cnt != 16'hFFFF) m_on_cnt <= m_on_cnt + 16'h0001;
            if (hour_tick && run_mode && m_run_cnt != 16'hFFFF) m_run_cnt <= m_run_cnt + 16'h0001;
            m_rd <= reg_rd ? rd_val(reg_addr) : 16'h0000;
            if (reg_wr && reg_addr < OSS_REG_STATE && reg_addr[1:0] == 2'b00) begin
                m_reg[reg_addr[5:2]] <= (reg_addr < OSS_REG_FREQ_LVL) ?
                    {8'h00, reg_wdata[7:0]} : reg_wdata;
            end
        end
    end

    always @(posedge clk_sys) m_term_d <= rst ? 3'b000 : m_term;

    always @(negedge clk_sys) begin
        if (!rst && run_chk) begin
            `CHK("term_out", m_term, term_out)
            `CHK("contact_q", m_term_d, contact_q)
            `CHK("reg_rdata", m_rd, reg_rdata)
            `CHK("irq", m_irq, irq)
        end
    end

    //------------------------------------------------------------------
    // Stimulus
    //------------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic bus_op(input logic wr, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        ce <= 1'b1;
        reg_wr <= wr;
        reg_rd <= ~wr;
        reg_addr <= a;
        reg_wdata <= d;
    endtask : bus_op

    task automatic drive_rand(input int n, input bit bus_en);
        int idx, op;
        repeat (n) begin
            @(posedge clk_sys);
            ce <= ($random(seed) & 7) != 0;
            {run_mode, motor_on, ramping} <= 3'($random(seed));
            {low_supply_flag, torque_clamp_flag} <= 2'($random(seed));
            {brake_release_req, brake_fault_flag} <= 2'($random(seed));
            out_freq <= 16'($random(seed)) & 16'h0007;
            set_freq <= 16'($random(seed)) & 16'h0007;
            out_current <= 16'($random(seed)) & 16'h001F;
            pid_error <= 16'($random(seed)) & 16'h001F;
            torque_est <= 16'($random(seed)) & 16'h001F;
            thermal_count <= 16'($random(seed)) & 16'h001F;
            alarm_event <= ($random(seed) & 31) == 0;
            alarm_clear <= ($random(seed) & 15) == 0;
            hour_tick <= ($random(seed) & 3) == 0;
            op = bus_en ? ($random(seed) & 3) : 3;
            idx = $random(seed) & 15;
            reg_rd <= op == 0;
            reg_wr <= op == 1;
            reg_addr <= 8'(idx * 4);
            if (idx < 3) reg_wdata <= {8'h00, codes[$random(seed) & 15]};
            else reg_wdata <= 16'($random(seed)) & 16'h001F;
        end
    endtask : drive_rand

    task automatic conclude;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    initial begin
        #(100 * 20000);
        error_cnt++;
        conclude();
    end

    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        run_chk <= 1'b1;
        for (int i = 0; i < 16; i++) bus_op(1'b0, 8'(i * 4), 16'h0000);
        drive_rand(4, 1'b0);
        $display("test reset_values done");
        for (int i = 0; i < 16; i++) begin
            bus_op(1'b1, OSS_REG_SEL2, {8'h00, codes[i]});
            bus_op(1'b1, OSS_REG_IRQ_MASK, 16'h000F);
            bus_op(1'b1, OSS_REG_FREQ_LVL, 16'h0003);
            drive_rand(40, 1'b0);
        end
        $display("test alarm_relay_codes done");
        drive_rand(8000, 1'b1);
        $display("test random_soak done");
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) bus_op(1'b0, 8'(i * 4), 16'h0000);
        drive_rand(200, 1'b1);
        $display("test mid_run_reset done");
        conclude();
    end
endmodule : tb_output_status_selector
